// [logic/cbt_consts.svh]
`ifndef CBT_CONSTS_SVH
`define CBT_CONSTS_SVH
`define CBT_DATA_W 10
`define CBT_HALF_LSB 0
`define CBT_HALF_MSB 5
`define CBT_CNT_LSB 0
`define CBT_CNT_MSB 7
`define CBT_HALF_RST 8'h01
`define CBT_RUN_RST 8'h00
`define CBT_AVG_RST 8'h00
`define CBT_BASE_RST 10'h000
`endif

// [logic/cbt_pkg.sv]
package cbt_pkg;
	typedef enum logic [1:0] {
		CBT_RISE = 2'b00,
		CBT_FALL = 2'b01,
		CBT_TOUCH = 2'b10
	} cbt_cond_t;
	typedef struct packed {
		logic [7:0] pass_step_limit;
		logic [7:0] noise_step_size;
		logic [7:0] noise_run_limit;
		logic [7:0] average_length;
	} cbt_set_t;
endpackage

// [logic/cbt_avg_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface cbt_avg_if #(parameter int W = 10);
	logic in_valid;
	logic [W-1:0] in_data;
	logic clear;
	logic [7:0] length;
	logic out_valid;
	logic [W-1:0] out_data;
	modport avg (input in_valid, in_data, clear, length,
		output out_valid, out_data);
	modport core (output in_valid, in_data, clear, length,
		input out_valid, out_data);
endinterface
`default_nettype wire

// [logic/cbt_avg.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cbt_consts.svh"
module cbt_avg
	import cbt_pkg::*;
#(
	parameter int W = 10
) (
	input wire logic core_clk,
	input wire logic rstn,
	cbt_avg_if.avg a
);
	logic [W+7:0] sum_reg, sum_next;
	logic [7:0] cnt_reg, cnt_next;
	logic vld_reg, vld_next;
	logic [W-1:0] dat_reg, dat_next;
	logic [7:0] target;
	logic [W+7:0] total;

	function automatic logic [7:0] decode_len(input logic [7:0] code);
		// code n gives n+1 samples, top code saturates at 255
		decode_len = (code == 8'hff) ? 8'hff : code + 8'h01;
	endfunction

	always_comb begin
		target = decode_len(a.length);
		total = sum_reg + {8'h00, a.in_data};
		sum_next = sum_reg;
		cnt_next = cnt_reg;
		vld_next = 1'b0;
		dat_next = dat_reg;
		if (a.clear) begin
			sum_next = '0;
			cnt_next = 8'h00;
		end else if (a.in_valid) begin
			if (cnt_reg + 8'h01 >= target) begin
				vld_next = 1'b1;
				dat_next = W'(total / {10'h000, target});
				sum_next = '0;
				cnt_next = 8'h00;
			end else begin
				sum_next = total;
				cnt_next = cnt_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sum_reg <= '0;
			cnt_reg <= 8'h00;
			vld_reg <= 1'b0;
			dat_reg <= '0;
		end else begin
			sum_reg <= sum_next;
			cnt_reg <= cnt_next;
			vld_reg <= vld_next;
			dat_reg <= dat_next;
		end
	end

	assign a.out_valid = vld_reg;
	assign a.out_data = dat_reg;

	avg_one_out_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(a.in_valid && !a.clear && decode_len(a.length) == 8'h01)
		|=> a.out_valid)
		else $error("average of one did not pass through");
	avg_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
		a.clear |=> !a.out_valid && cnt_reg == 8'h00)
		else $error("clear did not flush averager");
endmodule
`default_nettype wire

// [logic/cbt_step.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cbt_consts.svh"
module cbt_step
	import cbt_pkg::*;
#(
	parameter int W = 10
) (
	input wire logic [W-1:0] base,
	input wire logic [W-1:0] data,
	input wire logic [5:0] step,
	input wire logic up,
	output logic [W-1:0] stepped
);
	logic [W:0] wide;
	always_comb begin
		if (up) begin
			wide = {1'b0, base} + {{(W-5){1'b0}}, step};
			stepped = wide[W] ? {W{1'b1}} : wide[W-1:0];
			if (wide[W-1:0] > data && !wide[W])
				stepped = data;
		end else begin
			wide = {1'b0, base} - {{(W-5){1'b0}}, step};
			stepped = wide[W] ? {W{1'b0}} : wide[W-1:0];
			if (wide[W-1:0] < data && !wide[W])
				stepped = data;
		end
	end
endmodule
`default_nettype wire

// [logic/cbt_tracker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cbt_consts.svh"
module cbt_tracker
	import cbt_pkg::*;
#(
	parameter int W = `CBT_DATA_W
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic sample_valid,
	input wire logic [W-1:0] sample_data,
	input wire logic touched,
	input wire logic [7:0] rise_pass_step_limit,
	input wire logic [7:0] rise_noise_step_size,
	input wire logic [7:0] rise_noise_run_limit,
	input wire logic [7:0] rise_average_length,
	input wire logic [7:0] fall_pass_step_limit,
	input wire logic [7:0] fall_noise_step_size,
	input wire logic [7:0] fall_noise_run_limit,
	input wire logic [7:0] fall_average_length,
	input wire logic [7:0] touch_noise_step_size,
	input wire logic [7:0] touch_noise_run_limit,
	input wire logic [7:0] touch_average_length,
	output logic [W-1:0] baseline,
	output logic [1:0] condition,
	output logic [7:0] noise_count,
	output logic update_pulse
);
	cbt_cond_t cond_reg, cond_next, cond_now;
	logic [W-1:0] base_reg, base_next;
	logic [7:0] ncnt_reg, ncnt_next;
	logic upd_reg, upd_next;
	logic seeded_reg, seeded_next;
	cbt_set_t rise_set, fall_set, touch_set, act;
	logic cond_change;
	logic [W-1:0] diff;
	logic [W-1:0] stepped;
	logic [7:0] run_limit;
	logic [W-1:0] avg_val;

	cbt_avg_if #(.W(W)) avg_bus ();

	function automatic logic [7:0] decode_run(input logic [7:0] code);
		// code n gives n+1 samples, top code saturates at 255
		decode_run = (code == 8'hff) ? 8'hff : code + 8'h01;
	endfunction

	function automatic logic [W-1:0] abs_diff(input logic [W-1:0] x,
		input logic [W-1:0] y);
		abs_diff = (x > y) ? x - y : y - x;
	endfunction

	always_comb begin
		// only the low 6 bits of pass step limit and noise step size are honoured; run limit and average length keep all 8
		rise_set = '{{2'b00, rise_pass_step_limit[`CBT_HALF_MSB:0]},
			{2'b00, rise_noise_step_size[`CBT_HALF_MSB:0]},
			rise_noise_run_limit, rise_average_length};
		fall_set = '{{2'b00, fall_pass_step_limit[`CBT_HALF_MSB:0]},
			{2'b00, fall_noise_step_size[`CBT_HALF_MSB:0]},
			fall_noise_run_limit, fall_average_length};
		touch_set = '{8'h00, {2'b00, touch_noise_step_size[`CBT_HALF_MSB:0]},
			touch_noise_run_limit, touch_average_length};
	end

	// condition from raw input against baseline
	always_comb begin
		cond_now = cond_reg;
		if (touched)
			cond_now = CBT_TOUCH;
		else if (sample_data < base_reg)
			cond_now = CBT_FALL;
		else if (sample_data > base_reg)
			cond_now = CBT_RISE;
		else if (cond_reg == CBT_TOUCH)
			cond_now = CBT_RISE;
	end

	assign cond_change = sample_valid && seeded_reg && cond_now != cond_reg;

	always_comb begin
		case (cond_reg)
			CBT_RISE: act = rise_set;
			CBT_FALL: act = fall_set;
			CBT_TOUCH: act = touch_set;
			default: act = rise_set;
		endcase
	end

	assign avg_bus.in_valid = sample_valid && seeded_reg && !cond_change;
	assign avg_bus.in_data = sample_data;
	assign avg_bus.clear = cond_change;
	assign avg_bus.length = act.average_length;

	cbt_avg #(.W(W)) u_avg (
		.core_clk(core_clk),
		.rstn(rstn),
		.a(avg_bus.avg)
	);

	assign avg_val = avg_bus.out_data;
	assign diff = abs_diff(avg_val, base_reg);
	assign run_limit = decode_run(act.noise_run_limit);

	cbt_step #(.W(W)) u_step (
		.base(base_reg),
		.data(avg_val),
		.step(act.noise_step_size[5:0]),
		.up(avg_val > base_reg),
		.stepped(stepped)
	);

	always_comb begin
		cond_next = cond_reg;
		base_next = base_reg;
		ncnt_next = ncnt_reg;
		upd_next = 1'b0;
		seeded_next = seeded_reg;
		if (sample_valid && !seeded_reg) begin
			base_next = sample_data;
			seeded_next = 1'b1;
			cond_next = touched ? CBT_TOUCH : CBT_RISE;
		end else if (cond_change) begin
			cond_next = cond_now;
			ncnt_next = 8'h00;
		end else if (avg_bus.out_valid) begin
			upd_next = 1'b1;
			if (cond_reg != CBT_TOUCH &&
				{1'b0, diff} < {{(W-8){1'b0}}, act.pass_step_limit, 1'b0}) begin
				base_next = avg_val;
				ncnt_next = 8'h00;
			end else if (diff != '0) begin
				if (ncnt_reg + 8'h01 >= run_limit) begin
					base_next = stepped;
					ncnt_next = 8'h00;
				end else begin
					ncnt_next = ncnt_reg + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cond_reg <= CBT_RISE;
			base_reg <= `CBT_BASE_RST;
			ncnt_reg <= 8'h00;
			upd_reg <= 1'b0;
			seeded_reg <= 1'b0;
		end else begin
			cond_reg <= cond_next;
			base_reg <= base_next;
			ncnt_reg <= ncnt_next;
			upd_reg <= upd_next;
			seeded_reg <= seeded_next;
		end
	end

	assign baseline = base_reg;
	assign condition = cond_reg;
	assign noise_count = ncnt_reg;
	assign update_pulse = upd_reg;

	sequence change_seen;
		cond_change;
	endsequence
	sequence counters_zero;
		ncnt_reg == 8'h00 && !avg_bus.out_valid;
	endsequence

	cond_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
		change_seen |=> counters_zero)
		else $error("counters not cleared on condition change");
	fall_sel_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(cond_change && !touched && sample_data < base_reg)
		|=> cond_reg == CBT_FALL)
		else $error("falling not selected");
	rise_sel_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(cond_change && !touched && sample_data > base_reg)
		|=> cond_reg == CBT_RISE)
		else $error("rising not selected");
	small_pass_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(avg_bus.out_valid && seeded_reg && !cond_change
		&& cond_reg != CBT_TOUCH
		&& {1'b0, diff} < {{(W-8){1'b0}}, act.pass_step_limit, 1'b0})
		|=> base_reg == $past(avg_val))
		else $error("small delta not copied");
	noise_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(avg_bus.out_valid && seeded_reg && !cond_change && diff != '0
		&& ncnt_reg + 8'h01 < run_limit
		&& (cond_reg == CBT_TOUCH || {1'b0, diff}
		>= {{(W-8){1'b0}}, act.pass_step_limit, 1'b0}))
		|=> $stable(base_reg) && ncnt_reg == $past(ncnt_reg) + 8'h01)
		else $error("large delta not counted");
	first_step_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(avg_bus.out_valid && seeded_reg && !cond_change
		&& cond_reg == CBT_TOUCH && diff != '0 && run_limit == 8'h01)
		|=> base_reg != $past(base_reg))
		else $error("limit one did not step");
	touch_cond_a: assert property (@(posedge core_clk) disable iff (!rstn)
		(sample_valid && seeded_reg && touched) |=> cond_reg == CBT_TOUCH)
		else $error("touched condition not entered");
	one_update_a: assert property (@(posedge core_clk) disable iff (!rstn)
		update_pulse |=> !update_pulse)
		else $error("two updates for one sample");
endmodule
`default_nettype wire

// [testbench/cbt_feed.sv]
`timescale 1ns/1ps
`default_nettype none
module cbt_feed (
	input wire logic core_clk,
	output logic sample_valid,
	output logic [9:0] sample_data,
	output logic touched
);
	initial begin
		sample_valid = 1'b0;
		sample_data = 10'h000;
		touched = 1'b0;
	end
	// one pulse per filter period, data scrambled outside it
	task automatic send(input logic [9:0] d, input logic t);
		@(posedge core_clk);
		#1;
		sample_valid = 1'b1;
		sample_data = d;
		touched = t;
		@(posedge core_clk);
		#1;
		sample_valid = 1'b0;
		sample_data = ~d;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
	err_total++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module tb import cbt_pkg::*; ;
	typedef struct packed {
		logic [9:0] d;
		logic t;
		logic [9:0] b;
		logic [1:0] c;
		logic [7:0] n;
	} cbt_row_t;
	logic core_clk, rstn, sample_valid, touched, update_pulse;
	logic [9:0] sample_data, baseline;
	logic [1:0] condition;
	logic [7:0] noise_count;
	logic [7:0] r_psl, r_nss, r_nrl, r_avl, f_psl, f_nss, f_nrl, f_avl;
	logic [7:0] t_nss, t_nrl, t_avl;
	int err_total = 0;
	int checks_done = 0;
	int pulses = 0;
	int cycles = 0;
	int p0;
	cbt_row_t rows [14] = '{
		'{10'h1f4, 1'b0, 10'h1f4, CBT_RISE, 8'h00},
		'{10'h1f7, 1'b0, 10'h1f7, CBT_RISE, 8'h00},
		'{10'h208, 1'b0, 10'h1f7, CBT_RISE, 8'h01},
		'{10'h208, 1'b0, 10'h1fa, CBT_RISE, 8'h00},
		'{10'h190, 1'b0, 10'h1fa, CBT_FALL, 8'h00},
		'{10'h190, 1'b0, 10'h1f9, CBT_FALL, 8'h00},
		'{10'h1f8, 1'b0, 10'h1f8, CBT_FALL, 8'h00},
		'{10'h258, 1'b0, 10'h1f8, CBT_RISE, 8'h00},
		'{10'h190, 1'b0, 10'h1f8, CBT_FALL, 8'h00},
		'{10'h258, 1'b0, 10'h1f8, CBT_RISE, 8'h00},
		'{10'h12c, 1'b1, 10'h1f8, CBT_TOUCH, 8'h00},
		'{10'h12c, 1'b1, 10'h1f8, CBT_TOUCH, 8'h01},
		'{10'h12c, 1'b1, 10'h1f7, CBT_TOUCH, 8'h00},
		'{10'h1f7, 1'b0, 10'h1f7, CBT_RISE, 8'h00}
	};
	cbt_feed feed (
		.core_clk(core_clk),
		.sample_valid(sample_valid),
		.sample_data(sample_data),
		.touched(touched)
	);
	cbt_tracker dut (
		.core_clk(core_clk),
		.rstn(rstn),
		.sample_valid(sample_valid),
		.sample_data(sample_data),
		.touched(touched),
		.rise_pass_step_limit(r_psl),
		.rise_noise_step_size(r_nss),
		.rise_noise_run_limit(r_nrl),
		.rise_average_length(r_avl),
		.fall_pass_step_limit(f_psl),
		.fall_noise_step_size(f_nss),
		.fall_noise_run_limit(f_nrl),
		.fall_average_length(f_avl),
		.touch_noise_step_size(t_nss),
		.touch_noise_run_limit(t_nrl),
		.touch_average_length(t_avl),
		.baseline(baseline),
		.condition(condition),
		.noise_count(noise_count),
		.update_pulse(update_pulse)
	);
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check_idle;
		`CHK(baseline, 10'h000)
		`CHK(condition, CBT_RISE)
		`CHK(noise_count, 8'h00)
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (update_pulse === 1'b1) begin
			pulses++;
		end
		if (cycles == 1000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		rstn = 1'b0;
		{r_psl, r_nss, r_nrl, r_avl} = {8'h02, 8'h03, 8'h01, 8'h00};
		// falling set slower than rising
		{f_psl, f_nss, f_nrl, f_avl} = {8'h01, 8'h01, 8'h00, 8'h00};
		{t_nss, t_nrl, t_avl} = {8'h01, 8'h01, 8'h00};
		repeat (2) @(posedge core_clk);
		#1;
		check_idle();
		rstn = 1'b1;
		for (int i = 0; i < 14; i++) begin
			feed.send(rows[i].d, rows[i].t);
			`CHK(baseline, rows[i].b)
			`CHK(condition, rows[i].c)
			`CHK(noise_count, rows[i].n)
		end
		// two-sample mean of 504 and 506
		r_avl = 8'h01;
		p0 = pulses;
		feed.send(10'h1f8, 1'b0);
		`CHK(baseline, 10'h1f7)
		`CHK(pulses, p0)
		feed.send(10'h1fa, 1'b0);
		`CHK(baseline, 10'h1f9)
		`CHK(pulses, p0 + 1)
		// reset in mid-run, then reseed
		rstn = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		check_idle();
		rstn = 1'b1;
		feed.send(10'h064, 1'b0);
		`CHK(baseline, 10'h064)
		close_out();
	end
endmodule
`default_nettype wire
